// ===== timer2_defines.vh
`ifndef TIMER2_DEFINES_VH
`define TIMER2_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define IDX_IRQ_STATUS 10'h0c0
`define IDX_IRQ_MASK 10'h0c1
`define IDX_AUX_CTRL 10'h0c2
`define IDX_TIMER_CONTROL 10'h0c8
`define IDX_RELOAD_VALUE_LOW 10'h0ca
`define IDX_RELOAD_VALUE_HIGH 10'h0cb
`define IDX_COUNT_LOW_BYTE 10'h0cc
`define IDX_COUNT_HIGH_BYTE 10'h0cd

// ----------------------------------------------------------------
// timer_control field positions
// ----------------------------------------------------------------
`define TC_INPUT_SEL_LO 0
`define TC_INPUT_SEL_HI 1
`define TC_COMPARE_MODE_SEL 2
`define TC_RELOAD_MODE_LO 3
`define TC_RELOAD_MODE_HI 4
`define TC_PRESCALE_SEL 7

// ----------------------------------------------------------------
// status, mask and aux_ctrl field positions
// ----------------------------------------------------------------
`define ST_OVERFLOW_FLAG 0
`define ST_EXT_RELOAD_FLAG 1
`define AUX_EXT_RELOAD_IRQ_EN 0

// ----------------------------------------------------------------
// encodings of the two-bit fields
// ----------------------------------------------------------------
`define INSEL_STOP 2'h0
`define INSEL_TIMER 2'h1
`define INSEL_COUNTER 2'h2
`define INSEL_GATED 2'h3
`define RELOAD_ON_OVERFLOW 2'h2
`define RELOAD_ON_PIN 2'h3

// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define RESET_FLAGS 2'h0
`define OSC_DIV_FAST 6
`define OSC_DIV_SLOW 12

`endif

// ===== edge_fall.v
`timescale 1ns/1ps

// falling-edge detector for a pin that is already synchronous to hclk
module edge_fall (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // pin and event
    input wire pin,
    output wire fall
);

    reg prev_q;

    // starts high, so a pin held low through reset gives a falling edge in the first cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q <= 1'b1;
        end else if (ce) begin
            prev_q <= pin;
        end
    end

    assign fall = prev_q & ~pin;

endmodule // edge_fall

// ===== osc_prescaler.v
`timescale 1ns/1ps
`include "timer2_defines.vh"

// divides the oscillator (hclk) down to the timer count rate
module osc_prescaler #(
    parameter DIV_FAST = `OSC_DIV_FAST,
    parameter DIV_SLOW = `OSC_DIV_SLOW
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // rate select and tick
    input wire slow,
    output wire tick
);

    reg [3:0] cnt_q;
    wire [3:0] last;

    assign last = slow ? DIV_SLOW[3:0] - 4'h1 : DIV_FAST[3:0] - 4'h1;
    assign tick = (cnt_q >= last);

    // free running, so a rate change takes effect within one period
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 4'h0;
        end else if (ce) begin
            if (tick) begin
                cnt_q <= 4'h0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

endmodule // osc_prescaler

// ===== timer2_reload_input_control.v
// Function
// R01: reload off when upper bit 0; 10 reloads on overflow
// R02: mode 11 reloads on trigger pin falling edge
// R03: compare mode bit selects compare mode 0/1
// R04: input select 00 stops the timer
// R05: 01 counts at osc/6 or osc/12
// R06: 10 counts external count pin events
// R07: 11 counts prescaled only while gate permits
// R08: low count byte maps count bits 7:0
// R09: high count byte maps count bits 15:8
// R10: low reload byte holds reload bits 7:0
// R11: high reload byte holds reload bits 15:8
// R12: software keeps prescale clear in counter mode
// R13: overflow sets sticky flag until software clears
// R14: trigger falling edge sets flag when enabled
// R15: reload copies full reload value into count
// R16: reset clears counts, reload and all modes
`timescale 1ns/1ps
`include "timer2_defines.vh"

module timer2_reload_input_control #(
    parameter ADDR_W = 12
) (
    // clock, reset, enable
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // ahb-lite slave
    input wire hsel,
    input wire [ADDR_W-1:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // pins
    input wire reload_trigger_pin,
    input wire count_gate_pin,
    // to the compare/capture channels
    output reg compare_mode,
    output reg [15:0] count_value,
    output reg [15:0] reload_value,
    // interrupt
    output reg irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg [15:0] count_q;
    reg [15:0] count_d;
    reg [15:0] reload_q;
    reg [15:0] reload_d;
    reg [7:0] timer_control_q;
    reg [7:0] timer_control_d;
    reg [1:0] status_q;
    reg [1:0] status_d;
    reg [1:0] mask_q;
    reg [1:0] mask_d;
    reg aux_q;
    reg aux_d;

    // ahb data-phase bookkeeping
    reg wr_pend_q;
    reg rd_pend_q;
    reg [9:0] idx_q;

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    wire [1:0] input_sel;
    wire [1:0] reload_mode;
    wire prescale_sel;
    wire ext_reload_irq_en;

    assign input_sel = {timer_control_q[`TC_INPUT_SEL_HI], timer_control_q[`TC_INPUT_SEL_LO]};
    assign reload_mode = {timer_control_q[`TC_RELOAD_MODE_HI],
                          timer_control_q[`TC_RELOAD_MODE_LO]};
    assign prescale_sel = timer_control_q[`TC_PRESCALE_SEL];
    assign ext_reload_irq_en = aux_q;

    // ----------------------------------------------------------------
    // count sources
    // ----------------------------------------------------------------
    wire presc_tick;
    wire trig_fall;
    wire count_fall;

    // prescale_sel is ignored by the event counter, which counts the same whether it is set or clear
    osc_prescaler u_presc ( // R05 R12
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .slow(prescale_sel),
        .tick(presc_tick)
    );

    edge_fall u_trig_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .pin(reload_trigger_pin),
        .fall(trig_fall)
    );

    edge_fall u_count_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .pin(count_gate_pin),
        .fall(count_fall)
    );

    reg inc;

    always @* begin
        case (input_sel)
            `INSEL_STOP: inc = 1'b0; // R04
            `INSEL_TIMER: inc = presc_tick; // R05
            `INSEL_COUNTER: inc = count_fall; // R06
            `INSEL_GATED: inc = presc_tick & count_gate_pin; // R07
            default: inc = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // events
    // ----------------------------------------------------------------
    wire overflow;
    wire pin_reload;
    wire ovf_reload;

    assign overflow = inc & (count_q == 16'hffff);
    assign ovf_reload = overflow & (reload_mode == `RELOAD_ON_OVERFLOW); // R01
    assign pin_reload = trig_fall & (reload_mode == `RELOAD_ON_PIN); // R02

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire take;
    wire [9:0] idx_a;
    wire wr_cur;

    assign take = hsel & hready & htrans[1];
    assign idx_a = haddr[ADDR_W-1:2];
    assign wr_cur = wr_pend_q & hready;

    wire wr_tc;
    wire wr_rl;
    wire wr_rh;
    wire wr_cl;
    wire wr_ch;
    wire wr_st;
    wire wr_mk;
    wire wr_ax;

    assign wr_tc = wr_cur & (idx_q == `IDX_TIMER_CONTROL);
    assign wr_rl = wr_cur & (idx_q == `IDX_RELOAD_VALUE_LOW);
    assign wr_rh = wr_cur & (idx_q == `IDX_RELOAD_VALUE_HIGH);
    assign wr_cl = wr_cur & (idx_q == `IDX_COUNT_LOW_BYTE);
    assign wr_ch = wr_cur & (idx_q == `IDX_COUNT_HIGH_BYTE);
    assign wr_st = wr_cur & (idx_q == `IDX_IRQ_STATUS);
    assign wr_mk = wr_cur & (idx_q == `IDX_IRQ_MASK);
    assign wr_ax = wr_cur & (idx_q == `IDX_AUX_CTRL);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always @* begin
        count_d = count_q;
        if (pin_reload | ovf_reload) begin
            count_d = reload_q; // R15
        end else if (inc) begin
            count_d = count_q + 16'h0001;
        end
        // a software byte write wins over a same-cycle count
        if (wr_cl) begin
            count_d[7:0] = hwdata[7:0]; // R08
        end
        if (wr_ch) begin
            count_d[15:8] = hwdata[7:0]; // R09
        end
    end

    always @* begin
        reload_d = reload_q;
        if (wr_rl) begin
            reload_d[7:0] = hwdata[7:0]; // R10
        end
        if (wr_rh) begin
            reload_d[15:8] = hwdata[7:0]; // R11
        end
    end

    always @* begin
        timer_control_d = timer_control_q;
        if (wr_tc) begin
            // bits 6 and 5 belong to other units and stay zero here
            timer_control_d = hwdata[7:0] & 8'h9f;
        end
    end

    always @* begin
        mask_d = mask_q;
        aux_d = aux_q;
        if (wr_mk) begin
            mask_d = hwdata[1:0];
        end
        if (wr_ax) begin
            aux_d = hwdata[`AUX_EXT_RELOAD_IRQ_EN];
        end
    end

    // write-one-to-clear, then set; a same-cycle event survives the clear
    always @* begin
        status_d = status_q;
        if (wr_st) begin
            status_d = status_q & ~hwdata[1:0];
        end
        if (overflow) begin
            status_d[`ST_OVERFLOW_FLAG] = 1'b1; // R13
        end
        if (trig_fall & ext_reload_irq_en) begin
            status_d[`ST_EXT_RELOAD_FLAG] = 1'b1; // R14
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    reg [7:0] rd_byte;

    always @* begin
        case (idx_q)
            `IDX_TIMER_CONTROL: rd_byte = timer_control_q;
            `IDX_RELOAD_VALUE_LOW: rd_byte = reload_q[7:0]; // R10
            `IDX_RELOAD_VALUE_HIGH: rd_byte = reload_q[15:8]; // R11
            `IDX_COUNT_LOW_BYTE: rd_byte = count_q[7:0]; // R08
            `IDX_COUNT_HIGH_BYTE: rd_byte = count_q[15:8]; // R09
            `IDX_IRQ_STATUS: rd_byte = {6'h00, status_q};
            `IDX_IRQ_MASK: rd_byte = {6'h00, mask_q};
            `IDX_AUX_CTRL: rd_byte = {7'h00, aux_q};
            default: rd_byte = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= `RESET_WORD; // R16
            reload_q <= `RESET_WORD;
            timer_control_q <= `RESET_BYTE;
            status_q <= `RESET_FLAGS;
            mask_q <= `RESET_FLAGS;
            aux_q <= 1'b0;
        end else if (ce) begin
            count_q <= count_d;
            reload_q <= reload_d;
            timer_control_q <= timer_control_d;
            status_q <= status_d;
            mask_q <= mask_d;
            aux_q <= aux_d;
        end
    end

    // reads take one wait state so the data comes straight from a flop
    // and already reflects a write that finished in the cycle before
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            idx_q <= 10'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else if (ce) begin
            hresp <= 1'b0;
            if (rd_pend_q) begin
                hrdata <= {24'h000000, rd_byte};
                hreadyout <= 1'b1;
                rd_pend_q <= 1'b0;
            end else if (hready) begin
                wr_pend_q <= take & hwrite;
                rd_pend_q <= take & ~hwrite;
                hreadyout <= ~(take & ~hwrite);
                if (take) begin
                    idx_q <= idx_a;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs to the channels and interrupt
    // ----------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_mode <= 1'b0;
            count_value <= `RESET_WORD;
            reload_value <= `RESET_WORD;
            irq <= 1'b0;
        end else if (ce) begin
            compare_mode <= timer_control_d[`TC_COMPARE_MODE_SEL]; // R03
            count_value <= count_d;
            reload_value <= reload_d;
            irq <= |(status_d & mask_d);
        end
    end

endmodule // timer2_reload_input_control

// ===== timer2_checker.sv
`timescale 1ns/1ps
`include "timer2_defines.vh"

module timer2_checker #(
    parameter ADDR_W = 12
) (
    // clock, reset, enable
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // bus
    input wire hsel,
    input wire [ADDR_W-1:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    // pins
    input wire reload_trigger_pin,
    input wire count_gate_pin,
    // outputs
    input wire compare_mode,
    input wire [15:0] count_value,
    input wire [15:0] reload_value
);
    // ------------------------------------------------
    // shadow of write phases and of the control byte
    // ------------------------------------------------
    logic wp_q;
    logic trg_q;
    logic cnt_q;
    logic [9:0] wi_q;
    logic [7:0] ctl_q;
    wire [7:0] wb = hwdata[7:0];
    wire wd = ce & wp_q;
    wire tf = ce & trg_q & ~reload_trigger_pin;
    wire cf = ce & cnt_q & ~count_gate_pin;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q <= 1'b0;
            wi_q <= 10'h000;
            ctl_q <= 8'h00;
            // edge flops start high so a low pin at reset counts as an edge
            trg_q <= 1'b1;
            cnt_q <= 1'b1;
        end else if (ce) begin
            if (hready) begin
                wp_q <= hsel & htrans[1] & hwrite;
                wi_q <= haddr[ADDR_W-1:2];
            end
            if (wp_q && wi_q == `IDX_TIMER_CONTROL) begin
                ctl_q <= wb;
            end
            trg_q <= reload_trigger_pin;
            cnt_q <= count_gate_pin;
        end
    end

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_PIN_RELOAD: assert property (
        ctl_q[4:3] == 2'b11 && ctl_q[1:0] == 2'b00 && tf && !wd
        |=> count_value == $past(reload_value)) else $error("pin reload missed");
    AST_CMP_MODE: assert property (
        compare_mode == ctl_q[2]) else $error("compare mode differs");
    AST_STOPPED: assert property (
        ctl_q[1:0] == 2'b00 && ctl_q[4:3] != 2'b11 && !wd
        |=> $stable(count_value)) else $error("stopped timer moved");
    AST_TIMER_RATE: assert property (
        ctl_q[1:0] == 2'b01 && !ctl_q[7] && !ctl_q[4] && !$past(wd)
        && count_value != $past(count_value)
        |=> ($stable(count_value) || $past(wd))[*5]) else $error("tick too soon");
    AST_EVENTS: assert property (
        ctl_q[1:0] == 2'b10 && ctl_q[4:3] != 2'b11 && !wd && !cf
        |=> $stable(count_value)) else $error("count without pin edge");
    AST_GATED: assert property (
        ctl_q[1:0] == 2'b11 && ctl_q[4:3] != 2'b11 && !wd && !count_gate_pin
        |=> $stable(count_value)) else $error("count with gate closed");
    AST_CNT_LO: assert property (
        wd && wi_q == `IDX_COUNT_LOW_BYTE
        |=> count_value[7:0] == $past(wb)) else $error("count low write lost");
    AST_CNT_HI: assert property (
        wd && wi_q == `IDX_COUNT_HIGH_BYTE
        |=> count_value[15:8] == $past(wb)) else $error("count high write lost");
    AST_REL_LO: assert property (
        wd && wi_q == `IDX_RELOAD_VALUE_LOW
        |=> reload_value[7:0] == $past(wb)) else $error("reload low write lost");
    AST_REL_HI: assert property (
        wd && wi_q == `IDX_RELOAD_VALUE_HIGH
        |=> reload_value[15:8] == $past(wb)) else $error("reload high write lost");
    AST_OVF_RELOAD: assert property (
        ctl_q[4:0] == 5'h11 && !wd && count_value == 16'hffff ##1 count_value != 16'hffff
        |-> count_value == reload_value) else $error("overflow did not reload");

    cover property (tf && ctl_q[4:3] == 2'b11);
    cover property (cf && ctl_q[1:0] == 2'b10);
    cover property (wd && wi_q == `IDX_TIMER_CONTROL);
endmodule // timer2_checker

// ===== pin_model.sv
`timescale 1ns/1ps

// pins idle high, as behind a pull-up
module pin_model (
    // clock
    input wire hclk,
    // pins
    output logic trig,
    output logic gate
);
    initial begin
        trig = 1'b1;
        gate = 1'b1;
    end

    task automatic pull_trig();
        @(posedge hclk) trig <= 1'b0;
        @(posedge hclk) trig <= 1'b1;
    endtask

    // low time varies so slow and prompt sources are both seen
    task automatic events(input int n);
        repeat (n) begin
            @(posedge hclk) gate <= 1'b0;
            repeat (1 + $urandom % 3) @(posedge hclk);
            gate <= 1'b1;
            @(posedge hclk);
        end
    endtask

    task automatic set_gate(input logic v);
        @(posedge hclk) gate <= v;
    endtask
endmodule // pin_model

// ===== timer2_reload_input_control_tb_top.sv
`timescale 1ns/1ps
`include "timer2_defines.vh"

module timer2_reload_input_control_tb_top;
    logic hclk, hresetn, ce, hsel, hwrite;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, r;
    logic [15:0] v, e;
    wire hreadyout, hresp, compare_mode, irq, trig, gate;
    wire [31:0] hrdata;
    wire [15:0] count_value, reload_value;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;

    timer2_reload_input_control #(.ADDR_W(12)) dut (.hclk(hclk), .hresetn(hresetn),
        .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .reload_trigger_pin(trig),
        .count_gate_pin(gate), .compare_mode(compare_mode),
        .count_value(count_value), .reload_value(reload_value), .irq(irq));
    pin_model pins (.hclk(hclk), .trig(trig), .gate(gate));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task chk(input string s, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", s, ex, got);
        end
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop;
        end
    end

    task bus(input logic w, input logic [9:0] i, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {i, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
        #1;
    endtask

    task wr(input logic [9:0] i, input logic [7:0] d);
        bus(1'b1, i, d);
    endtask

    task rd(input logic [9:0] i);
        bus(1'b0, i, 8'h00);
    endtask

    // edges until the count moves; a second call gives the tick period
    task gap(output int c);
        logic [15:0] p;
        p = count_value;
        c = 0;
        do begin
            @(posedge hclk);
            c++;
        end while (count_value === p && c < 200);
    endtask

    initial begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hsize = 3'h2;
        hwdata = 32'h0;
        void'($urandom(56265));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk("out_rst", 32'h0, {count_value, reload_value});
        for (int k = 0; k < 14; k++) begin
            rd(10'h0c0 + 10'(k));
            chk("reg_rst", 32'h0, r);
        end
        $display("reset test done");
        for (int k = 0; k < 4; k++) begin
            v[7:0] = 8'($urandom);
            wr(`IDX_RELOAD_VALUE_LOW + 10'(k), v[7:0]);
            rd(`IDX_RELOAD_VALUE_LOW + 10'(k));
            chk("byte_rw", 32'(v[7:0]), r);
            chk("byte_out", 32'(v[7:0]), 32'({count_value, reload_value} >> (8 * k))
                & 32'hff);
        end
        wr(10'h0c5, 8'h5a);
        rd(10'h0c5);
        chk("unmapped", 32'h0, r);
        wr(`IDX_TIMER_CONTROL, 8'h64);
        rd(`IDX_TIMER_CONTROL);
        chk("ctl_rsvd", 32'h04, r);
        chk("cmp_on", 32'h1, 32'(compare_mode));
        wr(`IDX_TIMER_CONTROL, 8'h00);
        chk("cmp_off", 32'h0, 32'(compare_mode));
        $display("register test done");
        for (int ps = 0; ps < 2; ps++) begin
            wr(`IDX_TIMER_CONTROL, ps ? 8'h81 : 8'h01);
            gap(n);
            gap(n);
            chk("rate", ps ? `OSC_DIV_SLOW : `OSC_DIV_FAST, 32'(n));
        end
        wr(`IDX_TIMER_CONTROL, 8'h00);
        v = count_value;
        repeat (30) @(posedge hclk);
        chk("stopped", 32'(v), 32'(count_value));
        $display("rate test done");
        wr(`IDX_IRQ_MASK, 8'h01);
        for (int m = 0; m < 3; m++) begin
            // top bit clear so a reload cannot land back inside the wrap wait
            e = 16'($urandom) & 16'h7fff;
            wr(`IDX_RELOAD_VALUE_LOW, e[7:0]);
            wr(`IDX_RELOAD_VALUE_HIGH, e[15:8]);
            wr(`IDX_COUNT_LOW_BYTE, 8'hfd);
            wr(`IDX_COUNT_HIGH_BYTE, 8'hff);
            wr(`IDX_TIMER_CONTROL, 8'(m << 3) | 8'h01);
            n = 0;
            while (count_value[15:2] === 14'h3fff && n < 100) begin
                @(posedge hclk);
                n++;
            end
            chk("wrap", m == 2 ? 32'(e) : 32'h0, 32'(count_value));
            wr(`IDX_TIMER_CONTROL, 8'h00);
            rd(`IDX_IRQ_STATUS);
            chk("ovf_flag", 32'h1, r);
            chk("ovf_irq", 32'h1, 32'(irq));
            wr(`IDX_IRQ_MASK, 8'h00);
            chk("irq_masked", 32'h0, 32'(irq));
            wr(`IDX_IRQ_MASK, 8'h01);
            wr(`IDX_IRQ_STATUS, 8'h01);
            rd(`IDX_IRQ_STATUS);
            chk("ovf_clear", 32'h0, r | 32'(irq));
        end
        $display("overflow test done");
        wr(`IDX_TIMER_CONTROL, 8'h18);
        wr(`IDX_AUX_CTRL, 8'h01);
        wr(`IDX_IRQ_MASK, 8'h02);
        e = 16'($urandom);
        wr(`IDX_RELOAD_VALUE_LOW, e[7:0]);
        wr(`IDX_RELOAD_VALUE_HIGH, e[15:8]);
        pins.pull_trig();
        repeat (3) @(posedge hclk);
        #1;
        chk("pin_reload", 32'(e), 32'(count_value));
        chk("pin_irq", 32'h1, 32'(irq));
        rd(`IDX_IRQ_STATUS);
        chk("pin_flag", 32'h2, r);
        wr(`IDX_IRQ_STATUS, 8'h02);
        wr(`IDX_AUX_CTRL, 8'h00);
        wr(`IDX_TIMER_CONTROL, 8'h00);
        wr(`IDX_COUNT_LOW_BYTE, 8'h00);
        pins.pull_trig();
        repeat (3) @(posedge hclk);
        rd(`IDX_IRQ_STATUS);
        chk("no_flag", 32'h0, r);
        chk("no_reload", 32'(e & 16'hff00), 32'(count_value));
        $display("pin reload test done");
        wr(`IDX_COUNT_HIGH_BYTE, 8'h00);
        wr(`IDX_TIMER_CONTROL, 8'h02);
        n = 1 + $urandom % 8;
        pins.events(n);
        repeat (3) @(posedge hclk);
        chk("events", 32'(n), 32'(count_value));
        pins.set_gate(1'b0);
        wr(`IDX_TIMER_CONTROL, 8'h03);
        v = count_value;
        repeat (40) @(posedge hclk);
        chk("gate_shut", 32'(v), 32'(count_value));
        pins.set_gate(1'b1);
        gap(n);
        gap(n);
        chk("gate_open", `OSC_DIV_FAST, 32'(n));
        // a low clock enable must freeze the running count
        ce <= 1'b0;
        @(posedge hclk);
        v = count_value;
        repeat (20) @(posedge hclk);
        chk("ce_hold", 32'(v), 32'(count_value));
        ce <= 1'b1;
        $display("counter test done");
        // reset again with counts, reload and input select non-zero
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk("out_rst2", 32'h0, {count_value, reload_value});
        rd(`IDX_TIMER_CONTROL);
        chk("ctl_rst2", 32'h0, r | 32'(compare_mode));
        $display("second reset test done");
        report_and_stop;
    end
endmodule // timer2_reload_input_control_tb_top

bind timer2_reload_input_control timer2_checker #(.ADDR_W(ADDR_W)) chk_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .reload_trigger_pin(reload_trigger_pin), .count_gate_pin(count_gate_pin),
    .compare_mode(compare_mode), .count_value(count_value),
    .reload_value(reload_value));
